// ### inc/lsbe_pkg.sv
// package of register map, field layout and timing constants for the load switch b one enable logic
`default_nettype none
package lsbe_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] GOOD_MASK_LOW_OFS = 8'h22;  // switch_b1_good_mask_low
   localparam logic [7:0] SOURCE_AND_MASK_OFS = 8'h23;  // switch_b1_source_and_mask
   localparam logic [7:0] EDGE_DELAYS_OFS = 8'h24;  // switch_b1_edge_delays

   // ****************************************
   // reset values (the one-time-programmed defaults)
   // ****************************************
   localparam logic [7:0] GOOD_MASK_LOW_RST = 8'h00;
   localparam logic [7:0] SOURCE_AND_MASK_RST = 8'h80;
   localparam logic [7:0] EDGE_DELAYS_RST = 8'h00;

   // ****************************************
   // field positions
   // ****************************************
   localparam int MASK_SWITCH_B_TWO_BIT = 1;  // mask_switch_b_two_good
   localparam int MASK_REG_A_THREE_BIT = 0;  // mask_regulator_a_three_good
   localparam int SOURCE_LSB = 2;  // enable_source_select [4:2]
   localparam int ON_DELAY_LSB = 0;  // turn_on_delay [2:0]
   localparam int OFF_DELAY_LSB = 3;  // turn_off_delay [5:3]
   localparam int GOOD_COUNT = 10;  // power-good flags that can gate the rail

   // ****************************************
   // enable source codes
   // ****************************************
   localparam logic [2:0] SRC_INPUT_ONE = 3'h0;
   localparam logic [2:0] SRC_INPUT_TWO = 3'h1;
   localparam logic [2:0] SRC_INPUT_FIVE = 3'h2;
   localparam logic [2:0] SRC_INPUT_FOUR = 3'h3;
   localparam logic [2:0] SRC_INPUT_THREE = 3'h4;
   localparam logic [2:0] SRC_THREE_AND_FOUR = 3'h5;
   localparam logic [2:0] SRC_INPUT_SIX = 3'h6;
   localparam logic [2:0] SRC_ALWAYS_ON = 3'h7;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 20;  // system clock rate
   localparam int TICK_US = 100;  // delay counter resolution in microseconds
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;  // 2000 cycles per tick
   localparam int TICKS_PER_MS = 1000 / TICK_US;  // 10 ticks per millisecond
   localparam int DELAY_W = 10;  // holds up to 64 ms in ticks

   // edge delay state machine, gray along off -> wait -> on -> wait -> off
   typedef enum logic [1:0] {
      LSBE_OFF = 2'b00,
      LSBE_ON_WAIT = 2'b01,
      LSBE_ON = 2'b11,
      LSBE_OFF_WAIT = 2'b10
   } lsbe_state_type;
endpackage
`default_nettype wire

// ### core/lsbe_tick_divider.sv
// divider that makes the one-cycle delay tick enable
`timescale 1ns/1ps
`default_nettype none
module lsbe_tick_divider #(
   parameter int DIVIDE = 2000  // clock cycles per tick
) (
   input wire logic clk,  // system clock
   input wire logic nrst,  // synchronous reset, active low
   input wire logic restart,  // realign the tick phase
   output logic tick  // one-cycle enable pulse
);
   // ****************************************
   // divider counter
   // ****************************************
   logic [15:0] count_reg;  // cycles left to the next tick

   // count down and fire at zero; restart realigns so a delay starts on a fresh phase
   always_ff @(posedge clk) begin
      if (!nrst || restart) begin
         count_reg <= 16'(DIVIDE - 1);
      end else if (count_reg == 16'h0) begin
         count_reg <= 16'(DIVIDE - 1);
      end else begin
         count_reg <= count_reg - 16'h1;
      end
   end

   // tick is registered so it stays glitch free
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tick <= 1'b0;
      end else begin
         tick <= (count_reg == 16'h0) && !restart;
      end
   end
endmodule
`default_nettype wire

// ### core/lsbe_enable_logic.sv
// enable sequencing logic for the load switch b one rail
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RQ1 - low mask register masks eight rail good flags
// RQ2 - second register masks switch b two, regulator a3
// RQ3 - source field selects control input or constant one
// RQ4 - code 101 ands inputs three and four
// RQ5 - turn-on delay table, code 011 is 8 ms
// RQ6 - turn-off delay table, code 110 open
// RQ7 - delays within ten percent of nominal
// RQ8 - combine bit drives switch b two too
// RQ9 - enable is delayed input and unmasked goods
module lsbe_enable_logic #(
   parameter logic [7:0] MASK_LOW_RESET = lsbe_pkg::GOOD_MASK_LOW_RST,  // otp default
   parameter logic [7:0] SOURCE_RESET = lsbe_pkg::SOURCE_AND_MASK_RST,  // otp default
   parameter logic [7:0] DELAY_RESET = lsbe_pkg::EDGE_DELAYS_RST,  // otp default
   parameter int TICK_DIVIDE = lsbe_pkg::TICK_CYCLES  // cycles per delay tick
) (
   input wire logic clk,  // 20 MHz system clock
   input wire logic nrst,  // synchronous reset, active low
   input wire logic [7:0] regAddr,  // register offset
   input wire logic [7:0] regWrData,  // write data
   input wire logic regWrEn,  // one-cycle write strobe
   output logic [7:0] regRdData,  // registered read data, one cycle after address
   input wire logic [6:1] controlInput,  // control input pins one to six
   input wire logic [5:0] stepDownGood,  // power_good_flag of step_down_one..six
   input wire logic loadSwitchAOneGood,  // power_good_flag of load_switch_a_one
   input wire logic regulatorATwoGood,  // power_good_flag of regulator_a_two
   input wire logic regulatorAThreeGood,  // power_good_flag of regulator_a_three
   input wire logic switchBTwoGood,  // power_good_flag of switch_b_two_regulator_a_one
   input wire logic combineSwitchBEnables,  // combine bit, same clock domain
   input wire logic switchBTwoOwnEnable,  // switch b two's own enable result
   output logic switchBOneEnable,  // rail enable for load_switch_b_one
   output logic switchBTwoEnable  // rail enable for switch b two
);
   import lsbe_pkg::*;

   // ****************************************
   // configuration registers
   // ****************************************
   logic [7:0] maskLow_reg;  // switch_b1_good_mask_low
   logic [7:0] sourceMask_reg;  // switch_b1_source_and_mask
   logic [7:0] delays_reg;  // switch_b1_edge_delays

   // writes land on their offsets; reserved bits are stored as written
   always_ff @(posedge clk) begin
      if (!nrst) begin
         maskLow_reg <= MASK_LOW_RESET;
         sourceMask_reg <= SOURCE_RESET;
         delays_reg <= DELAY_RESET;
      end else if (regWrEn) begin
         case (regAddr)
            GOOD_MASK_LOW_OFS: maskLow_reg <= regWrData;  // RQ1
            SOURCE_AND_MASK_OFS: sourceMask_reg <= regWrData;  // RQ2
            EDGE_DELAYS_OFS: delays_reg <= regWrData;
            default: ;  // unmapped offsets ignore writes
         endcase
      end
   end

   // read data from a flip-flop; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         regRdData <= 8'h00;
      end else begin
         case (regAddr)
            GOOD_MASK_LOW_OFS: regRdData <= maskLow_reg;
            SOURCE_AND_MASK_OFS: regRdData <= sourceMask_reg;
            EDGE_DELAYS_OFS: regRdData <= delays_reg;
            default: regRdData <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [6:1] ctlMeta_reg;  // first stage, read only by the second
   logic [6:1] ctlSync_reg;  // control pins in the clock domain
   logic [GOOD_COUNT-1:0] goodMeta_reg;  // first stage of the good flags
   logic [GOOD_COUNT-1:0] goodSync_reg;  // good flags in the clock domain
   logic [GOOD_COUNT-1:0] goodRaw;  // good flags in mask bit order

   // order: bit9 switch b two, bit8 regulator a3, bits 7..0 as the low mask register
   assign goodRaw = {switchBTwoGood, regulatorAThreeGood, regulatorATwoGood, loadSwitchAOneGood, stepDownGood};

   // pins and analog comparator outputs are asynchronous, so two flops each
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctlMeta_reg <= 6'h00;
         ctlSync_reg <= 6'h00;
         goodMeta_reg <= '0;
         goodSync_reg <= '0;
      end else begin
         ctlMeta_reg <= controlInput;
         ctlSync_reg <= ctlMeta_reg;
         goodMeta_reg <= goodRaw;
         goodSync_reg <= goodMeta_reg;
      end
   end

   // ****************************************
   // enable source and good gating
   // ****************************************
   logic selectedEnable;  // enable input chosen by the source field
   logic [GOOD_COUNT-1:0] goodMask;  // 1 removes that flag from the condition
   logic allGood;  // every unmasked flag is good

   // pick the control input for this rail
   always_comb begin
      unique case (sourceMask_reg[SOURCE_LSB +: 3])
         SRC_INPUT_ONE: selectedEnable = ctlSync_reg[1];  // RQ3
         SRC_INPUT_TWO: selectedEnable = ctlSync_reg[2];  // RQ3
         SRC_INPUT_FIVE: selectedEnable = ctlSync_reg[5];  // RQ3
         SRC_INPUT_FOUR: selectedEnable = ctlSync_reg[4];  // RQ3
         SRC_INPUT_THREE: selectedEnable = ctlSync_reg[3];  // RQ3
         SRC_THREE_AND_FOUR: selectedEnable = ctlSync_reg[3] & ctlSync_reg[4];  // RQ4
         SRC_INPUT_SIX: selectedEnable = ctlSync_reg[6];  // RQ3
         SRC_ALWAYS_ON: selectedEnable = 1'b1;  // RQ3
      endcase
   end

   // a set mask bit forces that flag's term true
   assign goodMask = {sourceMask_reg[MASK_SWITCH_B_TWO_BIT], sourceMask_reg[MASK_REG_A_THREE_BIT], maskLow_reg};  // RQ1 RQ2
   assign allGood = &(goodSync_reg | goodMask);  // RQ1 RQ2

   // ****************************************
   // edge delay lookup, in ticks
   // ****************************************
   // code 110 on the falling side has no printed value; it takes 32 ms like the rising side
   function automatic logic [DELAY_W-1:0] delayTicks(input logic [2:0] code);
      logic [DELAY_W-1:0] ms;
      ms = '0;
      case (code)
         3'h0: ms = 10'd0;
         3'h1: ms = 10'd2;
         3'h2: ms = 10'd4;
         3'h3: ms = 10'd8;
         3'h4: ms = 10'd16;
         3'h5: ms = 10'd24;
         3'h6: ms = 10'd32;
         default: ms = 10'd64;
      endcase
      delayTicks = DELAY_W'(ms * DELAY_W'(TICKS_PER_MS));
   endfunction

   logic [DELAY_W-1:0] onTicks;  // turn-on delay in ticks
   logic [DELAY_W-1:0] offTicks;  // turn-off delay in ticks
   assign onTicks = delayTicks(delays_reg[ON_DELAY_LSB +: 3]);  // RQ5
   assign offTicks = delayTicks(delays_reg[OFF_DELAY_LSB +: 3]);  // RQ6

   // ****************************************
   // delay state machine
   // ****************************************
   lsbe_state_type state_reg;  // delayed enable state
   logic [DELAY_W-1:0] remain_reg;  // ticks left in a pending delay
   logic tick;  // 100 us enable pulse
   logic startDelay;  // a new delay begins this cycle
   logic delayedEnable;  // selected enable after edge delays

   // the tick restarts at each delay start, so the wait is n whole ticks plus one cycle:
   // the error is a single clock, far inside the ten percent allowed
   lsbe_tick_divider #(
      .DIVIDE(TICK_DIVIDE)
   ) tickGen (
      .clk(clk),
      .nrst(nrst),
      .restart(startDelay),
      .tick(tick)
   );  // RQ7

   assign startDelay = ((state_reg == LSBE_OFF) && selectedEnable && (onTicks != '0)) ||
                       ((state_reg == LSBE_ON) && !selectedEnable && (offTicks != '0));

   // an edge that reverses during its wait cancels it without changing the output
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= LSBE_OFF;
      end else begin
         unique case (state_reg)
            LSBE_OFF: begin
               if (selectedEnable) begin
                  state_reg <= (onTicks == '0) ? LSBE_ON : LSBE_ON_WAIT;  // RQ5
               end
            end
            LSBE_ON_WAIT: begin
               if (!selectedEnable) begin
                  state_reg <= LSBE_OFF;  // short pulse never turns the rail on
               end else if (tick && remain_reg <= 10'd1) begin
                  state_reg <= LSBE_ON;  // RQ5
               end
            end
            LSBE_ON: begin
               if (!selectedEnable) begin
                  state_reg <= (offTicks == '0) ? LSBE_OFF : LSBE_OFF_WAIT;  // RQ6
               end
            end
            LSBE_OFF_WAIT: begin
               if (selectedEnable) begin
                  state_reg <= LSBE_ON;  // glitch low never drops the rail
               end else if (tick && remain_reg <= 10'd1) begin
                  state_reg <= LSBE_OFF;  // RQ6 RQ9
               end
            end
         endcase
      end
   end

   // load the delay at its start, count it down on each tick
   always_ff @(posedge clk) begin
      if (!nrst) begin
         remain_reg <= '0;
      end else if (startDelay) begin
         remain_reg <= (state_reg == LSBE_OFF) ? onTicks : offTicks;  // RQ5 RQ6
      end else if (tick && remain_reg != '0) begin
         remain_reg <= remain_reg - 10'd1;
      end
   end

   assign delayedEnable = (state_reg == LSBE_ON) || (state_reg == LSBE_OFF_WAIT);

   // ****************************************
   // rail enable outputs
   // ****************************************
   // registered so the switch control never sees a decode glitch
   always_ff @(posedge clk) begin
      if (!nrst) begin
         switchBOneEnable <= 1'b0;
         switchBTwoEnable <= 1'b0;
      end else begin
         switchBOneEnable <= delayedEnable && allGood;  // RQ9
         switchBTwoEnable <= combineSwitchBEnables ? (delayedEnable && allGood) : switchBTwoOwnEnable;  // RQ8
      end
   end
endmodule
`default_nettype wire

// ### bench/lsbe_asserts.sv
// checker of the switch b one enable logic port behaviour
`timescale 1ns/1ps
`default_nettype none
module lsbe_asserts
   import lsbe_pkg::*;
#(
   parameter logic [7:0] MASK_LOW_RESET = GOOD_MASK_LOW_RST, // otp default
   parameter logic [7:0] SOURCE_RESET = SOURCE_AND_MASK_RST, // otp default
   parameter logic [7:0] DELAY_RESET = EDGE_DELAYS_RST // otp default
) (
   input wire logic clk, // clock
   input wire logic nrst, // reset
   input wire logic [7:0] regAddr, // offset
   input wire logic [7:0] regWrData, // write data
   input wire logic regWrEn, // strobe
   input wire logic [7:0] regRdData, // read data
   input wire logic [6:1] controlInput, // pins
   input wire logic [5:0] stepDownGood, // goods
   input wire logic loadSwitchAOneGood, // good
   input wire logic regulatorATwoGood, // good
   input wire logic regulatorAThreeGood, // good
   input wire logic switchBTwoGood, // good
   input wire logic combineSwitchBEnables, // combine
   input wire logic switchBTwoOwnEnable, // own enable
   input wire logic switchBOneEnable, // rail enable
   input wire logic switchBTwoEnable // b two enable
);
   // ****************
   // shadow registers
   // ****************
   localparam int PIN_OF [8] = '{1, 2, 5, 4, 3, 3, 6, 1}; // pin per source code
   logic [7:0] maskReg, srcReg, dlyReg; // copies of the registers
   logic mapped, blocked, selLow; // decoded conditions
   logic [2:0] src; // source code
   // shadows follow writes, so no peeking inside the design is needed
   always_ff @(posedge clk) begin
      if (!nrst) begin
         maskReg <= MASK_LOW_RESET;
         srcReg <= SOURCE_RESET;
         dlyReg <= DELAY_RESET;
      end else if (regWrEn) begin
         if (regAddr == GOOD_MASK_LOW_OFS) maskReg <= regWrData;
         if (regAddr == SOURCE_AND_MASK_OFS) srcReg <= regWrData;
         if (regAddr == EDGE_DELAYS_OFS) dlyReg <= regWrData;
      end
   end
   assign src = srcReg[4:2];
   assign mapped = regAddr inside {GOOD_MASK_LOW_OFS, SOURCE_AND_MASK_OFS, EDGE_DELAYS_OFS};
   assign blocked = |(~{switchBTwoGood, regulatorAThreeGood, regulatorATwoGood, loadSwitchAOneGood,
      stepDownGood} & ~{srcReg[1:0], maskReg});
   assign selLow = src == SRC_ALWAYS_ON ? 1'b0 : src == SRC_THREE_AND_FOUR ?
      !(controlInput[3] && controlInput[4]) : !controlInput[PIN_OF[src]];
   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence wr_held;
      regWrEn && mapped ##1 !regWrEn && $stable(regAddr);
   endsequence
   unmapped_read_a: assert property (!mapped |=> regRdData == 8'h00)
      else $error("unmapped offset read not zero");
   write_readback_a: assert property (wr_held |=> regRdData == $past(regWrData, 2))
      else $error("written value not read back");
   good_gate_a: assert property (blocked [*5] |-> !switchBOneEnable)
      else $error("enable high with unmasked good low");
   select_low_a: assert property ((selLow && dlyReg[5:3] == 3'h0) [*5] |-> !switchBOneEnable)
      else $error("enable high with source low");
   always_on_a: assert property ((src == SRC_ALWAYS_ON && dlyReg[2:0] == 3'h0 && !blocked) [*6]
      |-> switchBOneEnable) else $error("constant source not enabling");
   rise_cause_a: assert property ($rose(switchBOneEnable) && srcReg == $past(srcReg, 4)
      |-> !$past(selLow, 3)) else $error("enable rose without source");
   combine_follow_a: assert property ($past(combineSwitchBEnables)
      |-> switchBTwoEnable == switchBOneEnable) else $error("combined enable differs");
   own_follow_a: assert property (nrst && !combineSwitchBEnables
      |=> switchBTwoEnable == $past(switchBTwoOwnEnable)) else $error("own enable not followed");
endmodule
bind lsbe_enable_logic lsbe_asserts #(.MASK_LOW_RESET(MASK_LOW_RESET), .SOURCE_RESET(SOURCE_RESET),
   .DELAY_RESET(DELAY_RESET)) u_chk (.clk, .nrst, .regAddr, .regWrData, .regWrEn, .regRdData,
   .controlInput, .stepDownGood, .loadSwitchAOneGood, .regulatorATwoGood, .regulatorAThreeGood,
   .switchBTwoGood, .combineSwitchBEnables, .switchBTwoOwnEnable, .switchBOneEnable, .switchBTwoEnable);
`default_nettype wire

// ### bench/lsbe_partner.sv
// model of the control pins and the other rails' good flags
`timescale 1ns/1ps
`default_nettype none
module lsbe_partner (
   input wire logic clk, // system clock
   input wire logic [6:1] pinLevel, // wanted pin levels
   input wire logic [9:0] goodLevel, // wanted goods, mask bit order
   output logic [6:1] controlInput, // pins
   output logic [9:0] goodOut, // good flags
   output logic ownEnable // b two own enable
);
   logic toggleReg = 1'b0; // toggles so a one cycle slip shows
   // pins are asynchronous, so they move away from the sampling edge
   always @(posedge clk) begin
      controlInput <= #7 pinLevel;
      goodOut <= #11 goodLevel;
      toggleReg <= !toggleReg;
   end
   assign ownEnable = toggleReg;
endmodule
`default_nettype wire

// ### bench/lsbe_enable_logic_tb_top.sv
// bench of the switch b one enable logic
`timescale 1ns/1ps
`default_nettype none
module lsbe_enable_logic_tb_top;
   import lsbe_pkg::*;
   localparam int DIV = 4; // short tick keeps 64 ms at 2560 cycles
   localparam int DMS [8] = '{0, 2, 4, 8, 16, 24, 32, 64}; // ms per delay code
   localparam logic [5:0] SEL [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c, 6'h20, 6'h00}; // pins
   localparam logic [5:0] KILL [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h08, 6'h20, 6'h3f}; // dropped
   logic clk = 1'b0; // clock
   logic nrst, regWrEn, combine, own, en1, en2; // controls and enables
   logic [7:0] regAddr, regWrData, regRdData; // register port
   logic [6:1] pinLevel, pins; // wanted and driven pins
   logic [9:0] goodLevel, goods, msk; // wanted and driven goods
   int failCount = 0; // mismatches
   int checksDone = 0; // comparisons
   int n; // measured cycles
   always #25 clk = !clk;
   lsbe_partner u_far (.clk, .pinLevel, .goodLevel, .controlInput(pins), .goodOut(goods), .ownEnable(own));
   lsbe_enable_logic #(.TICK_DIVIDE(DIV)) u_dut (.clk, .nrst, .regAddr, .regWrData, .regWrEn, .regRdData,
      .controlInput(pins), .stepDownGood(goods[5:0]), .loadSwitchAOneGood(goods[6]),
      .regulatorATwoGood(goods[7]), .regulatorAThreeGood(goods[8]), .switchBTwoGood(goods[9]),
      .combineSwitchBEnables(combine), .switchBTwoOwnEnable(own), .switchBOneEnable(en1),
      .switchBTwoEnable(en2));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      regAddr <= a;
      @(posedge clk);
      @(negedge clk);
      check(regRdData, exp);
      @(posedge clk);
   endtask
   // let syncs and state settle, then look at the rail
   task automatic settle(input logic e);
      repeat (8) @(posedge clk);
      @(negedge clk);
      check({7'h0, en1}, {7'h0, e});
      @(posedge clk);
   endtask
   task automatic waitEn(input logic lvl, output int c);
      c = 0;
      while (en1 !== lvl && c < 4000) begin
         @(negedge clk);
         c++;
      end
   endtask
   // delay allows one tick early, a few sync cycles late
   task automatic span(input int c, input int ms);
      check({7'h0, c >= ms * 10 * DIV - DIV && c <= ms * 10 * DIV + 8}, 8'h01);
   endtask
   task automatic completeRun();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      pinLevel = 6'h00;
      goodLevel = 10'h3ff;
      combine = 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(GOOD_MASK_LOW_OFS, 8'h00);
      rd(SOURCE_AND_MASK_OFS, 8'h80);
      rd(EDGE_DELAYS_OFS, 8'h00);
      wr(8'h25, 8'h5a);
      rd(8'h25, 8'h00);
      wr(EDGE_DELAYS_OFS, 8'hc0);
      rd(EDGE_DELAYS_OFS, 8'hc0);
      wr(EDGE_DELAYS_OFS, 8'h00);
      wr(GOOD_MASK_LOW_OFS, 8'hff);
      // every source code, with the wanted pin low and then high
      for (int c = 0; c < 8; c++) begin
         wr(SOURCE_AND_MASK_OFS, {3'h0, c[2:0], 2'h3});
         pinLevel <= 6'h3f ^ KILL[c];
         settle(c == 7);
         pinLevel <= SEL[c];
         settle(1'b1);
      end
      // each good flag alone unmasked and low
      for (int i = 0; i < 10; i++) begin
         msk = 10'h3ff ^ (10'h001 << i);
         wr(GOOD_MASK_LOW_OFS, msk[7:0]);
         wr(SOURCE_AND_MASK_OFS, {6'h07, msk[9:8]});
         goodLevel <= msk;
         settle(1'b0);
         goodLevel <= 10'h3ff;
         settle(1'b1);
      end
      wr(SOURCE_AND_MASK_OFS, 8'h1f);
      goodLevel <= 10'h000;
      settle(1'b1);
      combine <= 1'b1;
      settle(1'b1);
      check({7'h0, en2}, 8'h01);
      combine <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({7'h0, en2}, {7'h0, !own});
      wr(SOURCE_AND_MASK_OFS, 8'h03);
      pinLevel <= 6'h00;
      settle(1'b0);
      // both edge delays for every nonzero code
      for (int c = 1; c < 8; c++) begin
         wr(EDGE_DELAYS_OFS, {2'h0, c[2:0], c[2:0]});
         pinLevel <= 6'h01;
         waitEn(1'b1, n);
         span(n, DMS[c]);
         pinLevel <= 6'h00;
         waitEn(1'b0, n);
         span(n, DMS[c]);
      end
      // a pulse shorter than the turn-on delay never enables
      pinLevel <= 6'h01;
      repeat (200) @(posedge clk);
      pinLevel <= 6'h00;
      repeat (2800) @(posedge clk);
      settle(1'b0);
      completeRun();
   end
   initial begin
      repeat (40000) @(posedge clk);
      failCount++;
      completeRun();
   end
endmodule
`default_nettype wire
